// file: mcl_pkg.sv
// mcl_pkg: register map, field layout and carrier types for the margin
// converter code/clamp block. assumes a 32-bit axi4-lite slave in front.
package mcl_pkg;

  // ==========================================================================
  // register indices (printed offsets are not word aligned: byte = 4 * index)
  localparam logic [7:0] IDX_CH5_CTRL  = 8'h54;
  localparam logic [7:0] IDX_CH6_CTRL  = 8'h55;
  localparam logic [7:0] IDX_CH5_CODE  = 8'h5C;
  localparam logic [7:0] IDX_CH6_CODE  = 8'h5D;
  localparam logic [7:0] IDX_CH5_UPPER = 8'h64;
  localparam logic [7:0] IDX_CH6_UPPER = 8'h65;
  localparam logic [7:0] IDX_CH5_LOWER = 8'h6C;
  localparam logic [7:0] IDX_CH6_LOWER = 8'h6D;
  localparam logic [7:0] IDX_STATUS    = 8'h70;

  localparam int ADDR_W = 10;

  // ==========================================================================
  // field layout and reset values
  localparam int          CTRL_EN_BIT   = 2;
  localparam logic [7:0]  CTRL_MASK     = 8'h07;
  localparam logic [7:0]  CODE_MIDSCALE = 8'h7F;
  localparam logic [7:0]  UPPER_RESET   = 8'hFF;
  localparam logic [7:0]  LOWER_RESET   = 8'h00;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // midscale centre voltage choices
  typedef enum logic [1:0] {
    MCL_CTR_1V25 = 2'h0,
    MCL_CTR_1V00 = 2'h1,
    MCL_CTR_0V80 = 2'h2,
    MCL_CTR_0V60 = 2'h3
  } mcl_centre_t;

  // per-channel register set
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] code;
    logic [7:0] upper;
    logic [7:0] lower;
  } mcl_chan_regs_t;

  // what a channel drives into its converter
  typedef struct packed {
    logic        output_enable_bit;
    mcl_centre_t centre_voltage_select;
    logic [7:0]  code_value_bits;
  } mcl_conv_t;

endpackage

// file: mcl_top.sv
// mcl_top: axi4-lite register file and code clamp for channels 5 and 6.
// assumes clock_i at 40 mhz, bus master on the same clock, no interrupts.
`timescale 1ns/100ps
`default_nettype none

module mcl_top (
  // clock, reset, enable
  input  wire logic                clock_i,
  input  wire logic                srst_i,
  input  wire logic                ce_i,
  // axi4-lite write address
  input  wire logic                s_axi_awvalid_i,
  output logic                     s_axi_awready_o,
  input  wire logic [9:0]          s_axi_awaddr_i,
  // axi4-lite write data
  input  wire logic                s_axi_wvalid_i,
  output logic                     s_axi_wready_o,
  input  wire logic [31:0]         s_axi_wdata_i,
  input  wire logic [3:0]          s_axi_wstrb_i,
  // axi4-lite write response
  output logic                     s_axi_bvalid_o,
  input  wire logic                s_axi_bready_i,
  output logic [1:0]               s_axi_bresp_o,
  // axi4-lite read address
  input  wire logic                s_axi_arvalid_i,
  output logic                     s_axi_arready_o,
  input  wire logic [9:0]          s_axi_araddr_i,
  // axi4-lite read data
  output logic                     s_axi_rvalid_o,
  input  wire logic                s_axi_rready_i,
  output logic [31:0]              s_axi_rdata_o,
  output logic [1:0]               s_axi_rresp_o,
  // converter drive
  output mcl_pkg::mcl_conv_t       ch5_conv_o,
  output mcl_pkg::mcl_conv_t       ch6_conv_o
);

  // ==========================================================================
  // clamp function
  // upper check first, so with crossed clamps a code above the upper clamp takes the upper clamp, any other code the lower
  function automatic mcl_pkg::mcl_conv_t clamp_chan(input mcl_pkg::mcl_chan_regs_t r);
    mcl_pkg::mcl_conv_t c;
    c.centre_voltage_select = mcl_pkg::mcl_centre_t'(r.ctrl[1:0]);
    c.output_enable_bit     = r.ctrl[mcl_pkg::CTRL_EN_BIT]
                              && !(r.lower > r.upper);
    if (r.code > r.upper) begin
      c.code_value_bits = r.upper;
    end else if (r.code < r.lower) begin
      c.code_value_bits = r.lower;
    end else begin
      c.code_value_bits = r.code;
    end
    return c;
  endfunction

  // ==========================================================================
  // state
  mcl_pkg::mcl_chan_regs_t ch5, ch6, next_ch5, next_ch6;
  logic                    aw_held, w_held, next_aw_held, next_w_held;
  logic [7:0]              aw_idx, next_aw_idx;
  logic [7:0]              wbyte, next_wbyte;
  logic                    wlane0, next_wlane0;
  logic                    bvalid, next_bvalid;
  logic [1:0]              bresp, next_bresp;
  logic                    rvalid, next_rvalid;
  logic [31:0]             rdata, next_rdata;
  logic [1:0]              rresp, next_rresp;
  mcl_pkg::mcl_conv_t      conv5, conv6, next_conv5, next_conv6;

  logic       do_write;
  logic [7:0] ar_idx;
  logic       rd_hit;
  logic [7:0] rd_byte;
  logic       wr_hit;

  // address and data are held independently, so either may arrive first
  assign s_axi_awready_o = !aw_held && !bvalid;
  assign s_axi_wready_o  = !w_held && !bvalid;
  assign s_axi_arready_o = !rvalid;
  assign s_axi_bvalid_o  = bvalid;
  assign s_axi_bresp_o   = bresp;
  assign s_axi_rvalid_o  = rvalid;
  assign s_axi_rdata_o   = rdata;
  assign s_axi_rresp_o   = rresp;
  assign ch5_conv_o      = conv5;
  assign ch6_conv_o      = conv6;

  // address bits 1:0 and byte lanes 1 to 3 are ignored: one byte per register
  assign ar_idx   = s_axi_araddr_i[9:2];
  assign do_write = aw_held && w_held && !bvalid;

  // ==========================================================================
  // next-state logic
  always_comb begin
    next_ch5     = ch5;
    next_ch6     = ch6;
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_idx  = aw_idx;
    next_wbyte   = wbyte;
    next_wlane0  = wlane0;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_rvalid  = rvalid;
    next_rdata   = rdata;
    next_rresp   = rresp;
    wr_hit       = 1'b1;
    rd_hit       = 1'b1;
    rd_byte      = 8'h00;

    if (s_axi_awvalid_i && s_axi_awready_o) begin
      next_aw_held = 1'b1;
      next_aw_idx  = s_axi_awaddr_i[9:2];
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      next_w_held = 1'b1;
      next_wbyte  = s_axi_wdata_i[7:0];
      next_wlane0 = s_axi_wstrb_i[0];
    end

    // a write lands only once both halves are held and the last answer is gone
    if (do_write) begin
      case (aw_idx)
        mcl_pkg::IDX_CH5_CTRL:  if (wlane0) next_ch5.ctrl = wbyte & mcl_pkg::CTRL_MASK;
        mcl_pkg::IDX_CH6_CTRL:  if (wlane0) next_ch6.ctrl = wbyte & mcl_pkg::CTRL_MASK;
        mcl_pkg::IDX_CH5_CODE:  if (wlane0) next_ch5.code = wbyte;
        mcl_pkg::IDX_CH6_CODE:  if (wlane0) next_ch6.code = wbyte;
        mcl_pkg::IDX_CH5_UPPER: if (wlane0) next_ch5.upper = wbyte;
        mcl_pkg::IDX_CH6_UPPER: if (wlane0) next_ch6.upper = wbyte;
        mcl_pkg::IDX_CH5_LOWER: if (wlane0) next_ch5.lower = wbyte;
        mcl_pkg::IDX_CH6_LOWER: if (wlane0) next_ch6.lower = wbyte;
        // status is read-only: writes answer okay and change nothing
        mcl_pkg::IDX_STATUS:    wr_hit = 1'b1;
        default:                wr_hit = 1'b0;
      endcase
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = wr_hit ? mcl_pkg::RESP_OKAY : mcl_pkg::RESP_SLVERR;
    end else if (bvalid && s_axi_bready_i) begin
      next_bvalid = 1'b0;
    end

    if (s_axi_arvalid_i && s_axi_arready_o) begin
      // upper control bits always read zero since they hold no function
      case (ar_idx)
        mcl_pkg::IDX_CH5_CTRL:  rd_byte = ch5.ctrl;
        mcl_pkg::IDX_CH6_CTRL:  rd_byte = ch6.ctrl;
        mcl_pkg::IDX_CH5_CODE:  rd_byte = ch5.code;
        mcl_pkg::IDX_CH6_CODE:  rd_byte = ch6.code;
        mcl_pkg::IDX_CH5_UPPER: rd_byte = ch5.upper;
        mcl_pkg::IDX_CH6_UPPER: rd_byte = ch6.upper;
        mcl_pkg::IDX_CH5_LOWER: rd_byte = ch5.lower;
        mcl_pkg::IDX_CH6_LOWER: rd_byte = ch6.lower;
        mcl_pkg::IDX_STATUS:    rd_byte = {6'h00, conv6.output_enable_bit,
                                           conv5.output_enable_bit};
        default:                rd_hit = 1'b0;
      endcase
      next_rvalid = 1'b1;
      next_rdata  = {24'h000000, rd_byte};
      next_rresp  = rd_hit ? mcl_pkg::RESP_OKAY : mcl_pkg::RESP_SLVERR;
    end else if (rvalid && s_axi_rready_i) begin
      next_rvalid = 1'b0;
    end

    // registered drive so the converter never sees comparator glitches
    next_conv5 = clamp_chan(next_ch5);
    next_conv6 = clamp_chan(next_ch6);
  end

  // ==========================================================================
  // registers
  // ce_i low freezes everything, bus handshakes included; reset still wins
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ch5     <= '{mcl_pkg::CTRL_RESET, mcl_pkg::CODE_MIDSCALE,
                   mcl_pkg::UPPER_RESET, mcl_pkg::LOWER_RESET};
      ch6     <= '{mcl_pkg::CTRL_RESET, mcl_pkg::CODE_MIDSCALE,
                   mcl_pkg::UPPER_RESET, mcl_pkg::LOWER_RESET};
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_idx  <= 8'h00;
      wbyte   <= 8'h00;
      wlane0  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= mcl_pkg::RESP_OKAY;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= mcl_pkg::RESP_OKAY;
      conv5   <= '{1'b0, mcl_pkg::MCL_CTR_1V25, mcl_pkg::CODE_MIDSCALE};
      conv6   <= '{1'b0, mcl_pkg::MCL_CTR_1V25, mcl_pkg::CODE_MIDSCALE};
    end else if (ce_i) begin
      ch5     <= next_ch5;
      ch6     <= next_ch6;
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      aw_idx  <= next_aw_idx;
      wbyte   <= next_wbyte;
      wlane0  <= next_wlane0;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
      conv5   <= next_conv5;
      conv6   <= next_conv6;
    end
  end

endmodule

`default_nettype wire

// file: mcl_top_sva.sv
// mcl_top_sva: port-level checks on the margin converter block.
// assumes one write and one read in flight at most; ce_i low stalls the bus.
`timescale 1ns/100ps
`default_nettype none
module mcl_top_sva (
  // clock, reset and clock enable
  input wire logic               clock_i,
  input wire logic               srst_i,
  input wire logic               ce_i,
  // bus handshakes
  input wire logic               s_axi_awvalid_i,
  input wire logic               s_axi_awready_o,
  input wire logic               s_axi_wvalid_i,
  input wire logic               s_axi_wready_o,
  input wire logic               s_axi_bvalid_o,
  input wire logic               s_axi_arvalid_i,
  input wire logic               s_axi_arready_o,
  input wire logic               s_axi_rvalid_o,
  input wire logic [31:0]        s_axi_rdata_o,
  // converter drive
  input wire mcl_pkg::mcl_conv_t ch5_conv_o,
  input wire mcl_pkg::mcl_conv_t ch6_conv_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  // ==========================================================================
  // converter outputs
  reset_mid_a: assert property ($fell(srst_i) |->
    ch5_conv_o == 11'h07F && ch6_conv_o == 11'h07F) else $error("conv not midscale");
  // a reset moves the drive back to midscale, so the edge after reset is exempt
  conv5_hold_a: assert property (!$past(srst_i) && $changed(ch5_conv_o) |->
    $rose(s_axi_bvalid_o)) else $error("ch5 conv moved without write");
  conv6_hold_a: assert property (!$past(srst_i) && $changed(ch6_conv_o) |->
    $rose(s_axi_bvalid_o)) else $error("ch6 conv moved without write");
  // ==========================================================================
  // bus timing
  wr_resp_a: assert property ((ce_i && s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
    && s_axi_wready_o) ##1 ce_i |=> s_axi_bvalid_o) else $error("write answer late");
  rd_resp_a: assert property (ce_i && s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer late");
  b_refuse_a: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write taken while answering");
  r_refuse_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read taken while answering");
  rdata_hi_a: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0)
    else $error("read data above byte");
endmodule
bind mcl_top mcl_top_sva i_mcl_top_sva (
  .clock_i         (clock_i),
  .srst_i          (srst_i),
  .ce_i            (ce_i),
  .s_axi_awvalid_i (s_axi_awvalid_i),
  .s_axi_awready_o (s_axi_awready_o),
  .s_axi_wvalid_i  (s_axi_wvalid_i),
  .s_axi_wready_o  (s_axi_wready_o),
  .s_axi_bvalid_o  (s_axi_bvalid_o),
  .s_axi_arvalid_i (s_axi_arvalid_i),
  .s_axi_arready_o (s_axi_arready_o),
  .s_axi_rvalid_o  (s_axi_rvalid_o),
  .s_axi_rdata_o   (s_axi_rdata_o),
  .ch5_conv_o      (ch5_conv_o),
  .ch6_conv_o      (ch6_conv_o)
);
`default_nettype wire

// file: tb.sv
// tb: self-checking bench for mcl_top over axi4-lite.
// assumes mcl_pkg compiled first; clock 40 mhz.
`timescale 1ns/100ps
`default_nettype none
module tb;
  typedef struct packed {
    logic [7:0]  ch, ctrl, up, lo, code;
    logic [10:0] exp;
  } mcl_row_t;
  logic               clock_i = 0, srst_i = 1, ce_i = 1;
  logic               s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
  logic               s_axi_arvalid_i = 0, s_axi_rready_i = 0;
  logic               s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
  logic               s_axi_arready_o, s_axi_rvalid_o;
  logic [9:0]         s_axi_awaddr_i = 0, s_axi_araddr_i = 0;
  logic [31:0]        s_axi_wdata_i = 0, s_axi_rdata_o, rd_d;
  logic [3:0]         s_axi_wstrb_i = 4'hF;
  logic [1:0]         s_axi_bresp_o, s_axi_rresp_o, rsp;
  mcl_pkg::mcl_conv_t ch5_conv_o, ch6_conv_o;
  int                 err_count = 0, cmp_count = 0;
  // ch, ctrl, upper, lower, code, expected converter drive
  mcl_row_t rows [6] = '{
    '{8'h0, 8'h04, 8'hFF, 8'h00, 8'h7F, 11'h47F},
    '{8'h0, 8'h05, 8'h90, 8'h10, 8'hA0, 11'h590},
    '{8'h0, 8'h06, 8'h90, 8'h10, 8'h05, 11'h610},
    '{8'h1, 8'h07, 8'h90, 8'h10, 8'h50, 11'h750},
    '{8'h1, 8'h03, 8'h90, 8'h10, 8'h50, 11'h350},
    '{8'h1, 8'h04, 8'h20, 8'h30, 8'h50, 11'h020}};

  mcl_top i_mcl_top (
    .clock_i         (clock_i),
    .srst_i          (srst_i),
    .ce_i            (ce_i),
    .s_axi_awvalid_i (s_axi_awvalid_i),
    .s_axi_awready_o (s_axi_awready_o),
    .s_axi_awaddr_i  (s_axi_awaddr_i),
    .s_axi_wvalid_i  (s_axi_wvalid_i),
    .s_axi_wready_o  (s_axi_wready_o),
    .s_axi_wdata_i   (s_axi_wdata_i),
    .s_axi_wstrb_i   (s_axi_wstrb_i),
    .s_axi_bvalid_o  (s_axi_bvalid_o),
    .s_axi_bready_i  (s_axi_bready_i),
    .s_axi_bresp_o   (s_axi_bresp_o),
    .s_axi_arvalid_i (s_axi_arvalid_i),
    .s_axi_arready_o (s_axi_arready_o),
    .s_axi_araddr_i  (s_axi_araddr_i),
    .s_axi_rvalid_o  (s_axi_rvalid_o),
    .s_axi_rready_i  (s_axi_rready_i),
    .s_axi_rdata_o   (s_axi_rdata_o),
    .s_axi_rresp_o   (s_axi_rresp_o),
    .ch5_conv_o      (ch5_conv_o),
    .ch6_conv_o      (ch6_conv_o)
  );

  initial forever #12.5 clock_i = ~clock_i;

  // wide enough for a response code beside a full data word
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // a fresh edge first, so strobes are never assigned twice in one step
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    @(posedge clock_i);
    s_axi_awaddr_i  <= {idx, 2'h0};
    s_axi_wdata_i   <= {24'h0, d};
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i  <= 1'b1;
    s_axi_bready_i  <= 1'b1;
    do begin
      @(posedge clock_i);
      // nothing is taken at an edge where the clock enable was low
      if (s_axi_awready_o && ce_i) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o && ce_i) s_axi_wvalid_i <= 1'b0;
    end while (!(s_axi_bvalid_o && ce_i));
    rsp = s_axi_bresp_o;
    s_axi_bready_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] idx);
    @(posedge clock_i);
    s_axi_araddr_i  <= {idx, 2'h0};
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i  <= 1'b1;
    do begin
      @(posedge clock_i);
      if (s_axi_arready_o && ce_i) s_axi_arvalid_i <= 1'b0;
    end while (!(s_axi_rvalid_o && ce_i));
    rd_d = s_axi_rdata_o;
    rsp  = s_axi_rresp_o;
    s_axi_rready_i <= 1'b0;
  endtask

  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // watchdog: the sequence needs under two hundred cycles
  initial begin
    #(3000 * 25);
    err_count++;
    test_done();
  end

  initial begin
    repeat (12) @(posedge clock_i);
    srst_i <= 1'b0;
    chk(ch5_conv_o, 11'h07F);
    foreach (rows[i]) begin
      wr(8'h54 + rows[i].ch, rows[i].ctrl);
      wr(8'h64 + rows[i].ch, rows[i].up);
      wr(8'h6C + rows[i].ch, rows[i].lo);
      wr(8'h5C + rows[i].ch, rows[i].code);
      chk(rows[i].ch[0] ? ch6_conv_o : ch5_conv_o, rows[i].exp);
      rd(8'h5C + rows[i].ch);
      chk(rd_d, rows[i].code);
    end
    $display("row table done");
    // status: ch5 enabled, ch6 forced off by its crossed clamps
    rd(8'h70);
    chk({rsp, rd_d}, {2'h0, 32'h1});
    // lowering the lower clamp releases the forced-off output
    wr(8'h6D, 8'h10);
    chk(ch6_conv_o, 11'h420);
    wr(8'h55, 8'hFF);
    chk(ch6_conv_o, 11'h720);
    rd(8'h55);
    chk(rd_d, 32'h7);
    $display("control tests done");
    rd(8'h00);
    chk({rsp, rd_d}, {2'h2, 32'h0});
    wr(8'h00, 8'h55);
    chk({rsp, ch6_conv_o}, {2'h2, 11'h720});
    // lane 0 off: answered okay, nothing stored
    s_axi_wstrb_i <= 4'hE;
    wr(8'h5D, 8'h00);
    s_axi_wstrb_i <= 4'hF;
    chk({rsp, ch6_conv_o}, {2'h0, 11'h720});
    $display("unmapped tests done");
    @(posedge clock_i);
    srst_i <= 1'b1;
    @(posedge clock_i);
    srst_i <= 1'b0;
    rd(8'h5D);
    chk({ch6_conv_o, rd_d}, {11'h07F, 32'h7F});
    $display("reset test done");
    // a low clock enable must hold off the whole write
    ce_i <= 1'b0;
    fork
      wr(8'h5D, 8'h33);
      begin
        repeat (4) @(posedge clock_i);
        chk({s_axi_bvalid_o, ch6_conv_o}, {1'b0, 11'h07F});
        ce_i <= 1'b1;
      end
    join
    chk(ch6_conv_o, 11'h033);
    $display("clock enable test done");
    test_done();
  end
endmodule
`default_nettype wire
